// file: cfgid_regs.sv
// What this block does
// - Bits 21:17 of the channel word give the interrupt output count less one.
// - Bits 16:12 of the channel word give the peripheral port count less one.
// - Bits 6:4 of the channel word give the channel count less one.
// - Bit 2 and bit 1 hold the manager security and start pins at reset exit.
// - Bit 0 reads one only when peripheral request interfaces exist.
// - Bits 7:4 of the cache word give the cache line count less one.
// - Bits 2:0 of the cache word encode the line length, 4 to 32 bytes.
// - The start word holds the 32-bit start address seen at reset exit.
// - Bit N of the security word is zero for secure and one for non-secure.
// - The security bits are loaded from their init inputs at reset exit.
// - Security bits above the implemented interrupt count read zero.
//
// Purpose: Read-only configuration identity registers on Avalon-MM.
// Assumes: Tie-off inputs settle before reset is released.
// Notes: Every access answers one cycle after it is taken.
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module cfgid_regs
  import cfgid_pkg::*;
#(
  parameter int NUM_IRQ = 32,
  parameter int NUM_PERIPH = 32,
  parameter bit HAS_PERIPH = 1'b1,
  parameter int NUM_CHAN = 8,
  parameter int NUM_LINES = 16,
  parameter logic [2:0] LINE_LEN_CODE = CFGID_LEN_32B
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic manager_security_select_in,
  input wire logic start_at_address_in,
  input wire logic [31:0] start_address_in,
  input wire logic [31:0] irq_security_init_in
);
  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  // Tie-offs come from outside the clock domain, so they are synchronised
  // before being captured.
  localparam int SW = 66;
  logic [SW-1:0] pins_s;

  cfgid_sync3 #(.W(SW)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({manager_security_select_in, start_at_address_in,
               start_address_in, irq_security_init_in}),
    .sync_out(pins_s)
  );

  // ==========================================================================
  // Capture at reset exit
  // ==========================================================================
  // The capture waits for the synchroniser to fill after release, so the
  // registers reflect the levels held through reset, not the reset zeros.
  localparam logic [2:0] CAP_DELAY = 3'h4;
  logic [2:0] cap_cnt_q;
  logic captured_q;
  logic mgr_sec_q;
  logic boot_en_q;
  logic [31:0] start_addr_q;
  logic [31:0] irq_sec_q;

  wire logic cap_now = !captured_q && (cap_cnt_q == CAP_DELAY);
  wire logic [31:0] irq_impl_mask = (NUM_IRQ >= 32) ? 32'hffff_ffff :
                                    ((32'h1 << NUM_IRQ) - 32'h1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_q <= '0;
      captured_q <= 1'b0;
    end else if (clk_en && !captured_q) begin
      cap_cnt_q <= cap_cnt_q + 3'h1;
      captured_q <= cap_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgr_sec_q <= 1'b0;
      boot_en_q <= 1'b0;
      start_addr_q <= CFGID_RST_WORD;
      irq_sec_q <= CFGID_RST_WORD;
    end else if (clk_en && cap_now) begin
      mgr_sec_q <= pins_s[65];
      boot_en_q <= pins_s[64];
      start_addr_q <= pins_s[63:32];
      irq_sec_q <= pins_s[31:0] & irq_impl_mask;
    end
  end

  // ==========================================================================
  // Register words
  // ==========================================================================
  localparam logic [4:0] EVT_CODE = 5'(NUM_IRQ - 1);
  localparam logic [4:0] PER_CODE = 5'(NUM_PERIPH - 1);
  localparam logic [2:0] CHN_CODE = 3'(NUM_CHAN - 1);
  localparam logic [3:0] LINES_CODE = 4'(NUM_LINES - 1);

  logic [31:0] chan_word;
  logic [31:0] cache_word;
  always_comb begin
    chan_word = CFGID_RST_WORD;
    chan_word[CFGID_EVT_LSB +: 5] = EVT_CODE;
    chan_word[CFGID_PER_LSB +: 5] = HAS_PERIPH ? PER_CODE : 5'h00;
    chan_word[CFGID_CHN_LSB +: 3] = CHN_CODE;
    chan_word[CFGID_MGR_BIT] = mgr_sec_q;
    chan_word[CFGID_BOOT_BIT] = boot_en_q;
    chan_word[CFGID_PREQ_BIT] = HAS_PERIPH;
    cache_word = CFGID_RST_WORD;
    cache_word[CFGID_LINES_LSB +: 4] = LINES_CODE;
    cache_word[CFGID_LEN_LSB +: 3] = LINE_LEN_CODE;
  end

  // ==========================================================================
  // Avalon-MM slave
  // ==========================================================================
  // Writes are accepted and discarded; nothing here has a write path.
  cfgid_state_t state_q;
  logic [31:0] rdata_q;
  logic wait_q;

  wire logic req = avs_read || avs_write;
  wire logic [31:0] rd_sel =
    (avs_address == CFGID_OFS_CHAN) ? chan_word :
    (avs_address == CFGID_OFS_ICACHE) ? cache_word :
    (avs_address == CFGID_OFS_START) ? start_addr_q :
    (avs_address == CFGID_OFS_IRQSEC) ? irq_sec_q : CFGID_UNMAPPED_RD;
  wire logic [31:0] rd_word = avs_read ? rd_sel : CFGID_UNMAPPED_RD;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CFGID_IDLE;
      rdata_q <= CFGID_RST_WORD;
      wait_q <= 1'b1;
    end else if (clk_en) begin
      case (state_q)
        CFGID_IDLE: begin
          if (req) begin
            state_q <= CFGID_ANSWER;
            rdata_q <= rd_word;
            wait_q <= 1'b0;
          end
        end
        CFGID_ANSWER: begin
          state_q <= CFGID_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          state_q <= CFGID_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Each taken access is remembered here, so that its answer can be judged
  // on the bus pins rather than on the internal words that feed them; a
  // fault in the read path would otherwise slip past the field checks.
  wire logic taken = clk_en && (state_q == CFGID_IDLE) && req;
  logic [3:0] chk_addr_q;
  logic chk_rd_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_addr_q <= CFGID_OFS_CHAN;
      chk_rd_q <= 1'b0;
    end else if (taken) begin
      chk_addr_q <= avs_address;
      chk_rd_q <= avs_read;
    end
  end

  // A write answers with zero data; a read with the word it asked for.
  wire logic answer = !avs_waitrequest;
  wire logic ans_rd = answer && chk_rd_q;
  wire logic ans_wr = answer && !chk_rd_q;
  wire logic ans_chan = ans_rd && (chk_addr_q == CFGID_OFS_CHAN);
  wire logic ans_cache = ans_rd && (chk_addr_q == CFGID_OFS_ICACHE);
  wire logic ans_start = ans_rd && (chk_addr_q == CFGID_OFS_START);
  wire logic ans_irq = ans_rd && (chk_addr_q == CFGID_OFS_IRQSEC);

  // Fixed fields, as the internal words build them.
  a_chan_fields: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    chan_word[21:17] == EVT_CODE && chan_word[6:4] == CHN_CODE
    && chan_word[0] == HAS_PERIPH)
    else $error("channel word fields wrong");
  a_periph_count: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    chan_word[0] |-> chan_word[16:12] == PER_CODE)
    else $error("peripheral count wrong");
  a_cache_fields: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    cache_word[7:4] == LINES_CODE && cache_word[2:0] == LINE_LEN_CODE)
    else $error("cache word fields wrong");
  a_len_legal: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    cache_word[CFGID_LEN_LSB +: 3] >= CFGID_LEN_4B
    && cache_word[CFGID_LEN_LSB +: 3] <= CFGID_LEN_32B)
    else $error("line length code reserved");

  // Reset-exit snapshot.
  a_capture_mgr: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    clk_en && cap_now |=> mgr_sec_q == $past(pins_s[65])
    && boot_en_q == $past(pins_s[64]))
    else $error("reset-exit levels not captured");
  a_start_addr: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    clk_en && cap_now |=> start_addr_q == $past(pins_s[63:32]))
    else $error("start address not captured");
  a_irq_sec_load: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    clk_en && cap_now |=> irq_sec_q == ($past(pins_s[31:0]) & irq_impl_mask))
    else $error("security bits not loaded");
  a_irq_upper_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (irq_sec_q & ~irq_impl_mask) == 32'h0)
    else $error("unimplemented security bits set");
  // Once the snapshot is taken, only a new reset may move it.
  a_ro_stable: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    captured_q |=> $stable(start_addr_q) && $stable(irq_sec_q)
    && $stable(mgr_sec_q))
    else $error("read-only word changed");

  // Answers as software sees them on the bus.
  a_answer_time: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    clk_en && state_q == CFGID_IDLE && req |=> !avs_waitrequest
    ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  a_idle_wait: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    state_q == CFGID_IDLE |-> avs_waitrequest)
    else $error("wait released while idle");
  a_chan_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_chan |-> avs_readdata[CFGID_EVT_LSB +: 5] == EVT_CODE
    && avs_readdata[CFGID_CHN_LSB +: 3] == CHN_CODE
    && avs_readdata[CFGID_PREQ_BIT] == HAS_PERIPH)
    else $error("channel word read wrong");
  a_periph_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_chan && avs_readdata[CFGID_PREQ_BIT]
    |-> avs_readdata[CFGID_PER_LSB +: 5] == PER_CODE)
    else $error("peripheral count read wrong");
  a_boot_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_chan |-> avs_readdata[CFGID_MGR_BIT] == $past(mgr_sec_q)
    && avs_readdata[CFGID_BOOT_BIT] == $past(boot_en_q))
    else $error("reset-exit levels read wrong");
  a_cache_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_cache |-> avs_readdata[CFGID_LINES_LSB +: 4] == LINES_CODE
    && avs_readdata[CFGID_LEN_LSB +: 3] == LINE_LEN_CODE)
    else $error("cache word read wrong");
  a_start_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_start |-> avs_readdata == $past(start_addr_q))
    else $error("start word read wrong");
  a_irq_read: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_irq |-> avs_readdata == $past(irq_sec_q)
    && (avs_readdata & ~irq_impl_mask) == 32'h0)
    else $error("security word read wrong");
  a_write_quiet: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ans_wr |-> avs_readdata == CFGID_UNMAPPED_RD)
    else $error("write answered with data");

  // Enable low must freeze every register, the snapshot counter included.
  a_enable_freeze: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    !clk_en |=> $stable(state_q) && $stable(wait_q) && $stable(rdata_q)
    && $stable(cap_cnt_q) && $stable(captured_q))
    else $error("state moved while enable low");

  // Main scenarios that the bench should reach.
  c_read_chan: cover property (@(posedge ref_clk) disable iff (!rst_n)
    avs_read && avs_address == CFGID_OFS_CHAN && !avs_waitrequest);
  c_write_ign: cover property (@(posedge ref_clk) disable iff (!rst_n)
    avs_write && !avs_waitrequest);
  c_capture: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cap_now && clk_en);
  c_read_irq: cover property (@(posedge ref_clk) disable iff (!rst_n)
    ans_irq);
  c_frozen_req: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en && req);
endmodule

// file: cfgid_pkg.sv
// Purpose: Constants and types for the configuration identity registers.
// Assumes: Avalon-MM slave with 32-bit data, word addressed by byte offset.
// Notes: Offsets are byte addresses of aligned words.
package cfgid_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] CFGID_OFS_CHAN = 4'h0;
  localparam logic [3:0] CFGID_OFS_ICACHE = 4'h4;
  localparam logic [3:0] CFGID_OFS_START = 4'h8;
  localparam logic [3:0] CFGID_OFS_IRQSEC = 4'hc;
  localparam logic [31:0] CFGID_UNMAPPED_RD = 32'h0000_0000;
  localparam logic [31:0] CFGID_RST_WORD = 32'h0000_0000;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int CFGID_EVT_LSB = 17;
  localparam int CFGID_PER_LSB = 12;
  localparam int CFGID_CHN_LSB = 4;
  localparam int CFGID_MGR_BIT = 2;
  localparam int CFGID_BOOT_BIT = 1;
  localparam int CFGID_PREQ_BIT = 0;
  localparam int CFGID_LINES_LSB = 4;
  localparam int CFGID_LEN_LSB = 0;

  // Cache line length codes.
  localparam logic [2:0] CFGID_LEN_4B = 3'h2;
  localparam logic [2:0] CFGID_LEN_8B = 3'h3;
  localparam logic [2:0] CFGID_LEN_16B = 3'h4;
  localparam logic [2:0] CFGID_LEN_32B = 3'h5;

  // ==========================================================================
  // Bus carrier
  // ==========================================================================
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } cfgid_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } cfgid_rsp_t;

  typedef enum logic [1:0] {
    CFGID_IDLE = 2'b00,
    CFGID_ANSWER = 2'b01
  } cfgid_state_t;
endpackage

// file: cfgid_sync3.sv
// Purpose: Three-stage synchroniser for pin-level inputs.
// Assumes: The level is stable in a window of several cycles.
// Notes: The first stage feeds only the second; a change is taken when the
// second and third stages agree.
`timescale 1ns/1ps
module cfgid_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire logic [W-1:0] agree = ~(s2_q ^ s3_q);
  wire logic [W-1:0] out_d = (agree & s2_q) | (~agree & out_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (clk_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule

// file: cfgid_regs_tb_top.sv
// Purpose: Self-checking bench for the configuration identity registers.
// Assumes: Avalon-MM answer one cycle after the request is taken.
// Notes: Small build-time counts make the masking of upper bits visible.
`timescale 1ns/1ps
module cfgid_regs_tb_top;
  import cfgid_pkg::*;
  // ==========================================================================
  // Setup
  // ==========================================================================
  localparam int NI = 20;
  localparam int NP = 5;
  localparam int NC = 3;
  localparam int NL = 9;
  localparam logic [2:0] LEN = CFGID_LEN_16B;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mgr_in = 1'b0;
  logic boot_in = 1'b0;
  logic [31:0] start_in = 32'h0000_0000;
  logic [31:0] init_in = 32'h0000_0000;
  int n_fail = 0;
  int compares = 0;

  cfgid_regs #(.NUM_IRQ(NI), .NUM_PERIPH(NP), .HAS_PERIPH(1'b1),
    .NUM_CHAN(NC), .NUM_LINES(NL), .LINE_LEN_CODE(LEN)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .manager_security_select_in(mgr_in), .start_at_address_in(boot_in),
    .start_address_in(start_in), .irq_security_init_in(init_in));

  initial forever #2 ref_clk = ~ref_clk;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic test_done;
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request is held until the edge that samples waitrequest low.
  task automatic access(input logic [3:0] a, input logic wr,
                        output logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= 32'hffff_ffff;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_fail++;
      $display("[ERR] waitrequest expected 0 seen 1");
      test_done();
    end
  endtask

  task automatic do_reset(input logic m, input logic b,
                          input logic [31:0] s, input logic [31:0] ini);
    @(posedge ref_clk);
    mgr_in <= m;
    boot_in <= b;
    start_in <= s;
    init_in <= ini;
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Capture lands on the fifth edge after release; leave margin.
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic check_all(input logic m, input logic b,
                           input logic [31:0] s, input logic [31:0] ini);
    logic [31:0] d;
    logic [31:0] e0;
    e0 = (32'(NI - 1) << 17) | (32'(NP - 1) << 12) | (32'(NC - 1) << 4);
    e0 = e0 | {29'h0, m, b, 1'b1};
    access(CFGID_OFS_CHAN, 1'b0, d);
    chk("chan", e0, d);
    chk("present", 32'h1, {31'h0, d[0]});
    access(CFGID_OFS_ICACHE, 1'b0, d);
    chk("icache", {24'h0, 4'(NL - 1), 1'b0, LEN}, d);
    access(CFGID_OFS_START, 1'b0, d);
    chk("start", s, d);
    access(CFGID_OFS_IRQSEC, 1'b0, d);
    chk("irqsec", ini & 32'((64'h1 << NI) - 1), d);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic sc_capture;
    do_reset(1'b1, 1'b0, 32'h1234_5678, 32'hffff_ffff);
    check_all(1'b1, 1'b0, 32'h1234_5678, 32'hffff_ffff);
  endtask

  // Pins that move after reset exit must not reach the snapshot.
  task automatic sc_pins_move;
    @(posedge ref_clk);
    mgr_in <= 1'b0;
    boot_in <= 1'b1;
    start_in <= 32'hedcb_a987;
    init_in <= 32'h0000_0000;
    repeat (10) @(posedge ref_clk);
    check_all(1'b1, 1'b0, 32'h1234_5678, 32'hffff_ffff);
  endtask

  task automatic sc_writes;
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      access(4'(k * 4), 1'b1, d);
      chk("write data", CFGID_UNMAPPED_RD, d);
    end
    check_all(1'b1, 1'b0, 32'h1234_5678, 32'hffff_ffff);
    access(4'h1, 1'b0, d);
    chk("unmapped", CFGID_UNMAPPED_RD, d);
  endtask

  // A request made while the enable is low waits until it returns.
  task automatic sc_freeze;
    logic [31:0] d;
    fork
      access(CFGID_OFS_START, 1'b0, d);
      begin
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("frozen wait", 32'h1, {31'h0, avs_waitrequest});
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    chk("frozen read", 32'h1234_5678, d);
  endtask

  task automatic sc_rereset;
    do_reset(1'b0, 1'b1, 32'h8000_0001, 32'ha5a5_a5a5);
    check_all(1'b0, 1'b1, 32'h8000_0001, 32'ha5a5_a5a5);
  endtask

  initial begin
    sc_capture();
    sc_pins_move();
    sc_writes();
    sc_freeze();
    sc_rereset();
    test_done();
  end
endmodule
